// ==== flash_status_host.sv ====
// host controller driving a byte-wide parallel flash through its pins
// assumes an apb master on pclk and a flash with no clock of its own
// Operation
// - host reads data bus twice and compares toggle bit
// - no toggle means done; next read returns array data
// - toggling with timeout set: recheck, on failure send reset
// - after breaking off, restart from the first two reads
// - after timeout host resets before using other sectors
// - host reads window flag before and after extra erase, keeps only the after value in late
// - protect: id voltage on output strobe and A9, dir low
// - unprotect: id voltage, dir high, clears all sectors
`timescale 1ns/10ps
`include "flash_status_params.svh"
module flash_status_host #(
  parameter logic [15:0] ACC_CYC = 16'(`FSP_ACC_CYC),
  parameter logic [15:0] WP_CYC  = 16'(`FSP_WP_CYC),
  parameter logic [15:0] WPH_CYC = 16'(`FSP_WPH_CYC),
  parameter logic [15:0] OES_CYC = 16'(`FSP_OES_CYC),
  parameter logic [15:0] HV_CYC  = 16'(`FSP_HV_CYC)
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic [18:0]       flash_addr,
  input  wire  logic [7:0]  dq_i,
  output logic [7:0]        dq_o,
  output logic              dq_oe,
  output logic              ce_n,
  output logic              oe_n,
  output logic              we_n,
  output logic              idv_on_a9,
  output logic              idv_on_oe
);
  import flash_status_pkg::*;

  all_t q;
  all_t n;

  always_comb begin
    logic        go;
    logic        fin;
    logic        lw;
    logic        lh;
    logic [18:0] la;
    logic [7:0]  ld;
    logic        tog;
    logic        unmapped;
    logic [31:0] rd;
    go = 1'b0;
    fin = 1'b0;
    lw = 1'b0;
    lh = 1'b0;
    la = q.reg_addr;
    ld = q.reg_wdata;
    tog = 1'b0;
    unmapped = 1'b0;
    rd = 32'h0000_0000;
    n = q;
    // pin input synchroniser
    n.s1 = dq_i;
    n.s2 = q.s1;
    n.s3 = q.s2;

    // apb slave, zero wait states
    case (paddr)
      `FSP_OFF_CTRL:   rd = {26'h0, q.use_sect, q.abort, 1'b0, q.op};
      `FSP_OFF_ADDR:   rd = {13'h0, q.reg_addr};
      `FSP_OFF_WDATA:  rd = {24'h0, q.reg_wdata};
      `FSP_OFF_STATUS: rd = {16'h0, q.rdata, 3'h0, q.prot, q.late,
                             q.fail, q.done, q.busy};
      default: unmapped = 1'b1;
    endcase
    if (psel && !penable && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = unmapped ? 32'h0000_0000 : rd;
      n.pslverr = unmapped;
    end
    if (psel && penable && q.pready) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && !q.pslverr) begin
        case (paddr)
          `FSP_OFF_CTRL: begin
            if (pwdata[`FSP_CTRL_START] && !q.busy) begin
              n.op = op_t'(pwdata[2:0]);
              n.use_sect = pwdata[`FSP_CTRL_SECT];
              n.busy = 1'b1;
              n.st = ST_DECIDE;
              n.step = 3'h0;
              n.recheck = 1'b0;
              n.abort = 1'b0;
              n.fail = 1'b0;
            end
            if (pwdata[`FSP_CTRL_ABORT] && q.busy) begin
              n.abort = 1'b1;
            end
          end
          `FSP_OFF_ADDR:  n.reg_addr = pwdata[18:0];
          `FSP_OFF_WDATA: n.reg_wdata = pwdata[7:0];
          `FSP_OFF_STATUS: begin
            if (pwdata[`FSP_ST_DONE]) begin
              n.done = 1'b0;
            end
          end
          default: n.pslverr = 1'b0;
        endcase
      end
    end

    // sequencer: each op is a list of whole bus cycles
    case (q.st)
      ST_IDLE: begin
        // keep any start taken over apb this cycle
        if (q.busy) begin
          n.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        case (q.op)
          OP_READ: begin
            go = (q.step == 3'h0);
            fin = !go;
          end
          OP_WRITE: begin
            go = (q.step == 3'h0);
            lw = 1'b1;
            fin = !go;
          end
          OP_RESET_CMD: begin
            go = (q.step == 3'h0);
            lw = 1'b1;
            ld = `FSP_RESET_CMD;
            fin = !go;
          end
          OP_HV_PROT, OP_HV_UNPROT: begin
            go = (q.step == 3'h0);
            lw = 1'b1;
            lh = 1'b1;
            la[`FSP_A_PROT_DIR] = (q.op == OP_HV_UNPROT);
            fin = !go;
          end
          OP_HV_VERIFY: begin
            go = (q.step == 3'h0);
            lh = 1'b1;
            la[`FSP_A_ID_OR_PROT] = 1'b1;
            fin = !go;
            if (fin) begin
              n.prot = q.rdata[`FSP_BIT_PROTECT];
            end
          end
          OP_ERASE_ADD: begin
            // window flag read, extra erase write, window flag read
            go = (q.step != 3'h3);
            lw = (q.step == 3'h1);
            fin = !go;
            if (fin) begin
              n.late = q.rdata[`FSP_BIT_WINDOW];
            end
          end
          default: begin
            // toggle polling
            tog = q.use_sect ?
                  (q.first[`FSP_BIT_SECT_TOG] ^ q.rdata[`FSP_BIT_SECT_TOG]) :
                  (q.first[`FSP_BIT_BUSY_TOG] ^ q.rdata[`FSP_BIT_BUSY_TOG]);
            if (q.step == 3'h1) begin
              n.first = q.rdata;
            end
            if (q.step >= 3'h3) begin
              fin = 1'b1;
            end else if (q.abort) begin
              fin = 1'b1;
            end else if (q.step < 3'h2) begin
              go = 1'b1;
            end else if (!tog) begin
              go = 1'b1;
            end else if (q.recheck) begin
              n.fail = 1'b1;
              go = 1'b1;
              lw = 1'b1;
              ld = `FSP_RESET_CMD;
              n.step = 3'h3;
            end else begin
              // no launch here: the next pass relaunches from step 0
              n.recheck = q.rdata[`FSP_BIT_TIMEOUT];
              n.step = 3'h0;
            end
          end
        endcase
      end
      ST_SETUP: begin
        if (q.cnt == 16'h0000) begin
          n.st = ST_ACTIVE;
          n.oe_n = q.is_wr;
          n.we_n = !q.is_wr;
          n.cnt = !q.is_wr ? ACC_CYC : (q.is_hv ? HV_CYC : WP_CYC);
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      ST_ACTIVE: begin
        if (q.cnt != 16'h0000) begin
          n.cnt = q.cnt - 16'h0001;
        end else if (q.is_wr || (q.s2 == q.s3)) begin
          if (!q.is_wr) begin
            n.rdata = q.s3;
          end
          n.st = ST_RECOVER;
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          n.cnt = WPH_CYC;
        end
      end
      ST_RECOVER: begin
        if (q.cnt == 16'h0000) begin
          n.st = ST_DECIDE;
          n.ce_n = 1'b1;
          n.dq_oe = 1'b0;
          n.idv_a9 = 1'b0;
          n.idv_oe = 1'b0;
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (go) begin
      // write strobe only with output strobe high
      n.st = ST_SETUP;
      n.is_wr = lw;
      n.is_hv = lh;
      n.fa = la;
      n.dout = ld;
      n.dq_oe = lw && !lh;
      n.ce_n = 1'b0;
      n.oe_n = 1'b1;
      n.we_n = 1'b1;
      n.idv_a9 = lh;
      n.idv_oe = lh && lw;
      n.cnt = OES_CYC;
      if (q.step < 3'h3) begin
        n.step = q.step + 3'h1;
      end else begin
        n.step = 3'h4;
      end
      if ((q.op == OP_POLL) && (q.step == 3'h2) && !tog) begin
        n.step = 3'h3;
      end
    end
    if (fin) begin
      // a finish beats a software clear of done
      n.st = ST_IDLE;
      n.busy = 1'b0;
      n.done = 1'b1;
      n.abort = 1'b0;
      n.recheck = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign flash_addr = q.fa;
  assign dq_o       = q.dout;
  assign dq_oe      = q.dq_oe;
  assign ce_n       = q.ce_n;
  assign oe_n       = q.oe_n;
  assign we_n       = q.we_n;
  assign idv_on_a9  = q.idv_a9;
  assign idv_on_oe  = q.idv_oe;
endmodule

// ==== flash_status_params.svh ====
// offsets, field positions and cycle counts of the flash host controller
// assumes pclk at 25 MHz; all times are rounded to whole cycles
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH
`define FSP_CLK_MHZ        25
// apb register byte offsets
`define FSP_OFF_CTRL       12'h000
`define FSP_OFF_ADDR       12'h004
`define FSP_OFF_WDATA      12'h008
`define FSP_OFF_STATUS     12'h00c
// ctrl fields
`define FSP_CTRL_START     3
`define FSP_CTRL_ABORT     4
`define FSP_CTRL_SECT      5
// status fields
`define FSP_ST_DONE        1
// flash data bus status bits
`define FSP_BIT_PROTECT    0
`define FSP_BIT_SECT_TOG   2
`define FSP_BIT_WINDOW     3
`define FSP_BIT_TIMEOUT    5
`define FSP_BIT_BUSY_TOG   6
// flash address lines used in high voltage modes
`define FSP_A_ID_OR_PROT   1
`define FSP_A_PROT_DIR     6
`define FSP_RESET_CMD      8'hf0
// times in ns or us, as least figures
`define FSP_T_ACC_NS       120
`define FSP_T_WP_NS        50
`define FSP_T_WPH_NS       20
`define FSP_T_OES_NS       50
`define FSP_T_HV_US        100
`define FSP_SYNC_CYC       3
// derived counts, least times rounded up
`define FSP_ACC_CYC  (((`FSP_T_ACC_NS*`FSP_CLK_MHZ)+999)/1000+`FSP_SYNC_CYC)
`define FSP_WP_CYC   (((`FSP_T_WP_NS*`FSP_CLK_MHZ)+999)/1000)
`define FSP_WPH_CYC  (((`FSP_T_WPH_NS*`FSP_CLK_MHZ)+999)/1000)
`define FSP_OES_CYC  (((`FSP_T_OES_NS*`FSP_CLK_MHZ)+999)/1000)
`define FSP_HV_CYC   (`FSP_T_HV_US*`FSP_CLK_MHZ)
`endif

// ==== flash_status_pkg.sv ====
// types of the flash host controller
// counts and offsets live in flash_status_params.svh
package flash_status_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DECIDE  = 3'h1,
    ST_SETUP   = 3'h3,
    ST_ACTIVE  = 3'h2,
    ST_RECOVER = 3'h6
  } state_t;
  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_WRITE    = 3'h1,
    OP_POLL     = 3'h2,
    OP_ERASE_ADD = 3'h3,
    OP_HV_PROT  = 3'h4,
    OP_HV_UNPROT = 3'h5,
    OP_HV_VERIFY = 3'h6,
    OP_RESET_CMD = 3'h7
  } op_t;
  typedef struct packed {
    state_t      st;
    op_t         op;
    logic [2:0]  step;
    logic [15:0] cnt;
    logic        is_wr;
    logic        is_hv;
    logic        recheck;
    logic        abort;
    logic        use_sect;
    logic [18:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        busy;
    logic        done;
    logic        fail;
    logic        late;
    logic        prot;
    logic [7:0]  rdata;
    logic [7:0]  first;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [18:0] fa;
    logic [7:0]  dout;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        idv_a9;
    logic        idv_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } all_t;
endpackage

// ==== flash_status_host_assertions.sv ====
// assertions on the apb side and flash pins of the host controller
// bound to flash_status_host; one clock domain, pclk
`timescale 1ns/10ps
module flash_status_host_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [18:0] flash_addr,
  input wire logic        dq_oe,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        idv_on_a9,
  input wire logic        idv_on_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_inh; !we_n |-> oe_n && !ce_n; endproperty
  a_inh: assert property (p_inh) else $error("write not gated");
  property p_wide; $fell(we_n) |=> !we_n; endproperty
  a_wide: assert property (p_wide) else $error("short pulse");
  property p_cont; dq_oe |-> oe_n; endproperty
  a_cont: assert property (p_cont) else $error("bus clash");
  property p_hv; idv_on_oe |-> idv_on_a9 && !dq_oe; endproperty
  a_hv: assert property (p_hv) else $error("bad hv setup");
  property p_addr; !ce_n && !$past(ce_n) |-> $stable(flash_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_rd; $fell(oe_n) |-> !ce_n && !dq_oe ##1 !oe_n; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  c_err: cover property (pslverr);
  c_hv: cover property ($fell(we_n) && idv_on_oe);
  c_rd: cover property ($fell(oe_n));
endmodule
bind flash_status_host flash_status_host_assertions
  flash_status_host_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
  .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .idv_on_a9(idv_on_a9), .idv_on_oe(idv_on_oe));

// ==== flash_model.sv ====
// behavioural byte-wide flash, eight bytes deep, at the host's pins
// strobes act as events; no clock on this side
`timescale 1ns/10ps
module flash_model #(
  parameter int NRD = 3
) (
  input  wire logic [18:0] a,
  input  wire logic [7:0]  d,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        hv9,
  input  wire logic        hvoe,
  output logic [7:0]       q
);
  logic [7:0] mem [8];
  logic [7:0] last = 8'hff;
  logic       busy = 1'h0;
  logic       stuck = 1'h0;
  logic       tmo = 1'h0;
  logic       prot = 1'h0;
  logic       tog = 1'h0;
  int         rem = 0;
  realtime    tw = 0;
  initial begin
    q = 8'h00;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  always @(negedge oe_n or negedge ce_n) begin
    if (!ce_n && !oe_n) begin
      if (hv9) begin
        q = {7'h00, prot & a[1]};
      end else if (busy) begin
        tog = ~tog;
        q = {~last[7], tog, tmo, 2'h1, tog, 2'h0};
        rem = rem - 1;
        if (rem <= 0 && stuck) tmo = 1'h1;
        if (rem <= 0 && !stuck) busy = 1'h0;
      end else begin
        q = mem[a[2:0]];
      end
    end
  end
  // released bus shows the inverse of the last value
  always @(posedge oe_n or posedge ce_n) begin
    if (ce_n ^ oe_n) q = ~q;
  end
  always @(negedge we_n) tw = $realtime;
  always @(posedge we_n) begin
    if (!ce_n && oe_n && $realtime - tw >= 5.0) begin
      if (hv9 && hvoe) begin
        prot = !a[6];
      end else if (d == 8'hf0) begin
        busy = 1'h0;
        stuck = 1'h0;
        tmo = 1'h0;
      end else if (!busy && !prot) begin
        stuck = mem[a[2:0]] != 8'hff;
        if (!stuck) mem[a[2:0]] = d;
        last = d;
        busy = 1'h1;
        rem = NRD;
      end
    end
  end
endmodule

// ==== tb.sv ====
// self-checking bench for the flash host controller
// apb driven here; flash_model answers at the flash pins
`timescale 1ns/10ps
`include "flash_status_params.svh"
module tb;
  import flash_status_pkg::*;
  logic        pclk = '0;
  logic        presetn = '0;
  logic        psel = '0;
  logic        penable = '0;
  logic        pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, s, st;
  logic        pready, pslverr, e, oe, ce_n, oe_n, we_n, h9, ho;
  logic [18:0] fa;
  logic [7:0]  dq_o, fq, v;
  wire  [7:0]  dq = oe ? dq_o : fq;
  int          n_fail = 0;
  int          compares = 0;
  always #20 pclk = ~pclk;
  flash_status_host #(.HV_CYC(16'h0004)) flash_status_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(fa), .dq_i(dq),
    .dq_o(dq_o), .dq_oe(oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .idv_on_a9(h9), .idv_on_oe(ho));
  flash_model flash_model_i (.a(fa), .d(dq), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .hv9(h9), .hvoe(ho), .q(fq));
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, x, input string m);
    compares++;
    if (g !== x)
      bad($sformatf("%s got %h exp %h", m, g, x));
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) begin
      bad("apb timeout");
      tally_and_finish;
    end
    s = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic waitb(input int b, input logic x);
    int k;
    k = 0;
    do begin
      apb(1'h0, `FSP_OFF_STATUS, '0);
      k++;
    end while (s[b] !== x && k < 500);
    if (k >= 500) begin
      bad("status timeout");
      tally_and_finish;
    end
  endtask
  task automatic op(input op_t o, input logic [18:0] a,
                    input logic [7:0] d, input logic x);
    apb(1'h1, `FSP_OFF_ADDR, 32'(a));
    apb(1'h1, `FSP_OFF_WDATA, 32'(d));
    apb(1'h1, `FSP_OFF_CTRL, 32'(o) | 32'(x) << `FSP_CTRL_SECT
        | 32'h1 << `FSP_CTRL_START);
    waitb(`FSP_ST_DONE, 1'h1);
    st = s;
    apb(1'h1, `FSP_OFF_STATUS, 32'h1 << `FSP_ST_DONE);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `FSP_OFF_STATUS, '0);
    chk(s, 32'h0, "status reset");
    apb(1'h1, `FSP_OFF_ADDR, 32'hffff_ffff);
    apb(1'h0, `FSP_OFF_ADDR, '0);
    chk(s, 32'h0007_ffff, "addr field");
    apb(1'h0, 12'h010, '0);
    chk({s[31:1], e}, 32'h1, "unmapped");
    $display("test regs ended, n_fail %0d", n_fail);
    for (int i = 0; i < 2; i++) begin
      v = 8'h5a + 8'(i);
      op(OP_WRITE, 19'(2 + i), v, 1'h0);
      op(OP_POLL, 19'(2 + i), '0, 1'(i));
      chk(32'(st[15:0]), {16'h0, v, 8'h02}, "poll");
      op(OP_READ, 19'(2 + i), '0, 1'h0);
      chk(32'(st[15:8]), 32'(v), "array");
    end
    $display("test program ended, n_fail %0d", n_fail);
    op(OP_WRITE, 19'h2, 8'h0f, 1'h0);
    op(OP_POLL, 19'h2, '0, 1'h0);
    chk(32'(st[2:1]), 32'h3, "timeout");
    op(OP_READ, 19'h2, '0, 1'h0);
    chk(32'(st[15:8]), 32'h5a, "after reset");
    $display("test timeout ended, n_fail %0d", n_fail);
    op(OP_WRITE, 19'h2, 8'h0f, 1'h0);
    apb(1'h1, `FSP_OFF_CTRL, 32'(OP_POLL) | 32'h1 << `FSP_CTRL_START);
    repeat (2) apb(1'h0, `FSP_OFF_STATUS, '0);
    apb(1'h1, `FSP_OFF_CTRL, 32'h1 << `FSP_CTRL_ABORT);
    waitb(0, 1'h0);
    apb(1'h1, `FSP_OFF_STATUS, 32'h1 << `FSP_ST_DONE);
    op(OP_POLL, 19'h2, '0, 1'h0);
    chk(32'(st[2:1]), 32'h3, "restart");
    $display("test abort ended, n_fail %0d", n_fail);
    op(OP_HV_PROT, '0, '0, 1'h0);
    op(OP_HV_VERIFY, '0, '0, 1'h0);
    chk(32'(st[4]), 32'h1, "protected");
    op(OP_WRITE, 19'h6, 8'h00, 1'h0);
    op(OP_READ, 19'h6, '0, 1'h0);
    chk(32'(st[15:8]), 32'hff, "blocked");
    op(OP_HV_UNPROT, '0, '0, 1'h0);
    op(OP_HV_VERIFY, '0, '0, 1'h0);
    chk(32'(st[4]), 32'h0, "unprotected");
    $display("test protect ended, n_fail %0d", n_fail);
    op(OP_ERASE_ADD, 19'h7, 8'h30, 1'h0);
    chk(32'(st[3]), 32'h1, "late");
    op(OP_RESET_CMD, 19'h7, '0, 1'h0);
    op(OP_READ, 19'h7, '0, 1'h0);
    chk(32'(st[15:8]), 32'h30, "reset cmd");
    $display("test erase ended, n_fail %0d", n_fail);
    tally_and_finish;
  end
endmodule
